/* hw/bsc_cfg.svh */
// Offsets, field positions, reset values and setpoint constants for the buck setpoint registers
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH
`define BSC_BUCK2_OFFSET    8'h0f
`define BSC_BUCK3_OFFSET    8'h10
`define BSC_BUCK2_RESET     8'h08
`define BSC_BUCK3_RESET     8'h08
`define BSC_EXT_SEL_BIT     7
`define BSC_RSVD_BIT        6
`define BSC_CODE_MSB        5
`define BSC_CODE_LSB        0
`define BSC_BASE_MV         12'h384
`define BSC_STEP_MV         12'h019
`define BSC_MAX_MV          12'hce4
`define BSC_SAT_CODE        6'h38
`endif

/* hw/bsc_pkg.sv */
// Types shared by the buck setpoint register bank
package bsc_pkg;
	typedef logic [7:0]  bsc_reg_t;
	typedef logic [5:0]  bsc_code_t;
	typedef logic [11:0] bsc_mv_t;
endpackage

/* hw/bsc_regs.sv */
// Control registers of the second and third step-down converters
`timescale 1ns/10ps
`include "bsc_cfg.svh"

// Operation
// - third converter register at 0x10, reset 0x08
// - third converter writes need password unlock
// - bit7 zero selects register voltage code
// - bit7 one means external setpoint applies
// - bit6 reserved, reads zero, ignores writes
// - third code MSB and LSB fixed
// - second code LSB fixed, resets 00_1000b
// - second register 0x0f, reset 0x08, protected
module bsc_regs
	import bsc_pkg::*;
(
	input  wire logic     clk,            // 200 MHz internal clock
	input  wire logic     rst,            // Power-on reset, active high
	input  wire logic     wr_en,          // Register write strobe
	input  wire logic     rd_en,          // Register read strobe
	input  wire logic [7:0] addr,         // Register address
	input  wire logic [7:0] wr_data,      // Write data
	input  wire logic     pw_unlocked,    // Password sequence satisfied
	output logic [7:0]    rd_data,        // Registered read data
	output logic          buck2_external_adjust_sel, // Buck2 external source
	output logic          buck3_external_adjust_sel, // Buck3 external source
	output logic          buck2_use_code, // Buck2 follows its code
	output logic          buck3_use_code, // Buck3 follows its code
	output logic [11:0]   buck2_setpoint_mv, // Buck2 setpoint in mV, zero when external
	output logic [11:0]   buck3_setpoint_mv  // Buck3 setpoint in mV, zero when external
);
	// Writable masks: bit7 plus programmable code bits
	// Buck2 keeps only its code bit 0 fixed, so bits 5..1 are open
	localparam bsc_reg_t BUCK2_WMASK = 8'hbe;
	// Buck3 keeps code bits 5 and 0 fixed, so only bits 4..1 are open
	localparam bsc_reg_t BUCK3_WMASK = 8'h9e;

	// Register state
	// Both images hold the full byte so readback needs no reassembly;
	// the reserved and fixed bits simply never leave their reset value
	bsc_reg_t buck2_r, buck2_nxt;       // Buck2 register image
	bsc_reg_t buck3_r, buck3_nxt;       // Buck3 register image

	// Read path
	// Read data is held in a flop so the bus sees a stable byte
	bsc_reg_t rd_r, rd_nxt;             // Read data holding

	// Setpoint path
	// The setpoint trails the register by one clock; the converter
	// side must tolerate that single cycle of lag after each write
	bsc_mv_t  mv2_r, mv2_nxt;           // Buck2 setpoint
	bsc_mv_t  mv3_r, mv3_nxt;           // Buck3 setpoint

	// Source flags
	// Kept as their own flops so the outputs come straight from a
	// register, with no inverter between flop and pin
	logic     use2_r, use2_nxt;         // Buck2 follows its code
	logic     use3_r, use3_nxt;         // Buck3 follows its code

	// Code to millivolts with saturation at the top entry
	// The linear step alone never reaches the top voltage inside six
	// bits, so saturation is decided on the code, not on the sum
	function automatic bsc_mv_t code_to_mv(input bsc_code_t code);
		bsc_mv_t v;
		v = `BSC_BASE_MV + bsc_mv_t'(code) * `BSC_STEP_MV;
		if (code >= `BSC_SAT_CODE) begin
			// Every code from the top entry upwards gives the top voltage
			v = `BSC_MAX_MV;
		end
		return v;
	endfunction

	// Next-state for both registers, read data and setpoints
	always_comb begin
		buck2_nxt = buck2_r;
		buck3_nxt = buck3_r;
		rd_nxt    = rd_r;
		if (wr_en && pw_unlocked) begin
			if (addr == `BSC_BUCK2_OFFSET) begin
				// Only bit7 and code bits 5..1 change
				buck2_nxt = (buck2_r & ~BUCK2_WMASK) | (wr_data & BUCK2_WMASK);
			end else if (addr == `BSC_BUCK3_OFFSET) begin
				// Code bits 5 and 0 stay as reset
				buck3_nxt = (buck3_r & ~BUCK3_WMASK) | (wr_data & BUCK3_WMASK);
			end
		end
		if (rd_en) begin
			if (addr == `BSC_BUCK2_OFFSET) begin
				rd_nxt = buck2_r;
			end else if (addr == `BSC_BUCK3_OFFSET) begin
				rd_nxt = buck3_r;
			end else begin
				rd_nxt = 8'h00; // Unmapped address reads zero
			end
		end
		// External selection removes the code's influence
		mv2_nxt = buck2_r[`BSC_EXT_SEL_BIT] ? 12'h000 :
			code_to_mv(buck2_r[`BSC_CODE_MSB:`BSC_CODE_LSB]);
		mv3_nxt = buck3_r[`BSC_EXT_SEL_BIT] ? 12'h000 :
			code_to_mv(buck3_r[`BSC_CODE_MSB:`BSC_CODE_LSB]);
		// Source flags follow the next register value so they flip
		// on the same edge as the selection bit itself
		use2_nxt = ~buck2_nxt[`BSC_EXT_SEL_BIT];
		use3_nxt = ~buck3_nxt[`BSC_EXT_SEL_BIT];
	end

	// Register update
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			buck2_r <= `BSC_BUCK2_RESET;
			buck3_r <= `BSC_BUCK3_RESET;
			rd_r    <= 8'h00;
			mv2_r   <= 12'h000;
			mv3_r   <= 12'h000;
			use2_r  <= 1'b1;
			use3_r  <= 1'b1;
		end else begin
			buck2_r <= buck2_nxt;
			buck3_r <= buck3_nxt;
			rd_r    <= rd_nxt;
			mv2_r   <= mv2_nxt;
			mv3_r   <= mv3_nxt;
			use2_r  <= use2_nxt;
			use3_r  <= use3_nxt;
		end
	end

	assign rd_data                   = rd_r;
	assign buck2_external_adjust_sel = buck2_r[`BSC_EXT_SEL_BIT];
	assign buck3_external_adjust_sel = buck3_r[`BSC_EXT_SEL_BIT];
	assign buck2_use_code            = use2_r;
	assign buck3_use_code            = use3_r;
	assign buck2_setpoint_mv         = mv2_r;
	assign buck3_setpoint_mv         = mv3_r;

	// Write steps seen by the checks below
	// A write that the unlock lets through to the second register
	sequence s_open_write2;
		wr_en && pw_unlocked && addr == `BSC_BUCK2_OFFSET;
	endsequence
	// The second register then holds the masked byte of that write
	sequence s_buck2_took;
		buck2_r == ($past(wr_data) & 8'hbe);
	endsequence
	// A write that the unlock lets through to the third register
	sequence s_open_write3;
		wr_en && pw_unlocked && addr == `BSC_BUCK3_OFFSET;
	endsequence
	// The third register then holds the masked byte of that write
	sequence s_buck3_took;
		buck3_r == ($past(wr_data) & 8'h9e);
	endsequence

	// Locked write leaves the third register alone
	a_locked_buck3: assert property (@(posedge clk) disable iff (rst)
		(wr_en && !pw_unlocked && addr == `BSC_BUCK3_OFFSET) |=> $stable(buck3_r))
		else $error("buck3 changed without unlock");
	// Locked write leaves the second register alone
	a_locked_buck2: assert property (@(posedge clk) disable iff (rst)
		(wr_en && !pw_unlocked && addr == `BSC_BUCK2_OFFSET) |=> $stable(buck2_r))
		else $error("buck2 changed without unlock");
	// Reserved bit never leaves zero
	a_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
		!buck2_r[`BSC_RSVD_BIT] && !buck3_r[`BSC_RSVD_BIT])
		else $error("reserved bit set");
	// Fixed code bits of the third register stay put
	a_buck3_fixed: assert property (@(posedge clk) disable iff (rst)
		buck3_r[5] == 1'b0 && buck3_r[0] == 1'b0)
		else $error("buck3 fixed code bits moved");
	// Fixed code bit of the second register stays put
	a_buck2_fixed: assert property (@(posedge clk) disable iff (rst)
		buck2_r[0] == 1'b0)
		else $error("buck2 fixed code bit moved");
	// External mode drops the code setpoint one clock later
	a_ext_mv: assert property (@(posedge clk) disable iff (rst)
		buck3_r[7] |=> buck3_setpoint_mv == 12'h000)
		else $error("external mode still drives code setpoint");
	// Reset code gives the expected setpoint
	a_code_mv: assert property (@(posedge clk) disable iff (rst)
		(!buck2_r[7] && buck2_r[5:0] == 6'h08) |=> buck2_setpoint_mv == 12'h44c)
		else $error("buck2 code 8 not 1100 mV");
	// Highest reachable code is capped
	a_sat_mv: assert property (@(posedge clk) disable iff (rst)
		(!buck2_r[7] && buck2_r[5:0] == 6'h3e) |=> buck2_setpoint_mv == 12'hce4)
		else $error("top codes not capped at 3300 mV");
	// First saturating code is capped as well
	a_sat_edge: assert property (@(posedge clk) disable iff (rst)
		(!buck2_r[7] && buck2_r[5:0] == 6'h38) |=> buck2_setpoint_mv == 12'hce4)
		else $error("first top code not capped at 3300 mV");
	// Code just below the top still follows the linear step
	a_below_sat: assert property (@(posedge clk) disable iff (rst)
		(!buck2_r[7] && buck2_r[5:0] == 6'h36) |=> buck2_setpoint_mv == 12'h8ca)
		else $error("code below top not on the linear step");
	// Unlocked write to the third register lands masked
	a_write3: assert property (@(posedge clk) disable iff (rst)
		s_open_write3 |=> s_buck3_took)
		else $error("unlocked buck3 write not stored");
	// Unlocked write to the second register lands masked
	a_write2: assert property (@(posedge clk) disable iff (rst)
		s_open_write2 |=> s_buck2_took)
		else $error("unlocked buck2 write not stored");
	// Source flags always mirror the selection bits
	a_use_flags: assert property (@(posedge clk) disable iff (rst)
		buck2_use_code == !buck2_r[7] && buck3_use_code == !buck3_r[7])
		else $error("use flag disagrees with selection bit");
	// A read of the third register returns its value before the edge
	a_rd_buck3: assert property (@(posedge clk) disable iff (rst)
		(rd_en && addr == `BSC_BUCK3_OFFSET) |=> rd_data == $past(buck3_r))
		else $error("buck3 readback wrong");
endmodule

/* testbench/tb.sv */
// Self-checking bench for the buck setpoint register bank
`timescale 1ns/10ps
module tb
	import bsc_pkg::*;
;
	// One row: address, write data, unlock level, expected readback and setpoint
	typedef struct {bsc_reg_t a; bsc_reg_t d; logic u; bsc_reg_t rd; bsc_mv_t sp;} bsc_row_t;
	logic     clk, rst, wr_en, rd_en, pw_unlocked;
	bsc_reg_t addr, wr_data, rd_data;
	logic     b2_ext, b3_ext, b2_use, b3_use;
	bsc_mv_t  b2_mv, b3_mv;
	int       errors;
	int       check_count;
	bsc_row_t rows [10] = '{
		'{8'h0f, 8'hff, 1'b1, 8'hbe, 12'h000},
		'{8'h0f, 8'h37, 1'b1, 8'h36, 12'h8ca},
		'{8'h0f, 8'h39, 1'b1, 8'h38, 12'hce4},
		'{8'h0f, 8'h3f, 1'b1, 8'h3e, 12'hce4},
		'{8'h0f, 8'h10, 1'b1, 8'h10, 12'h514},
		'{8'h0f, 8'hff, 1'b0, 8'h10, 12'h514},
		'{8'h10, 8'hff, 1'b1, 8'h9e, 12'h000},
		'{8'h10, 8'h4c, 1'b1, 8'h0c, 12'h4b0},
		'{8'h10, 8'h21, 1'b0, 8'h0c, 12'h4b0},
		'{8'h20, 8'hff, 1'b1, 8'h00, 12'h4b0}};
	bsc_regs dut (.clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wr_data(wr_data), .pw_unlocked(pw_unlocked), .rd_data(rd_data),
		.buck2_external_adjust_sel(b2_ext), .buck3_external_adjust_sel(b3_ext),
		.buck2_use_code(b2_use), .buck3_use_code(b3_use),
		.buck2_setpoint_mv(b2_mv), .buck3_setpoint_mv(b3_mv));
	// Free-running 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Compare one value and count it
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One strobed access, then let read data and setpoint settle
	task automatic acc(input bsc_reg_t a, input bsc_reg_t d, input logic u, input logic w);
		@(posedge clk);
		wr_en <= w;
		rd_en <= !w;
		addr <= a;
		wr_data <= d;
		pw_unlocked <= u;
		@(posedge clk);
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// Read back a register and check the matching converter outputs
	task automatic rd_chk(input bsc_reg_t a, input bsc_reg_t erd, input bsc_mv_t emv);
		acc(a, 8'h00, 1'b0, 1'b0);
		chk({8'h00, rd_data}, {8'h00, erd});
		chk({4'h0, (a == 8'h0f) ? b2_mv : b3_mv}, {4'h0, emv});
		chk({15'h0, (a == 8'h0f) ? b2_use : b3_use}, {15'h0, ~erd[7]});
		chk({15'h0, (a == 8'h0f) ? b2_ext : b3_ext}, {15'h0, erd[7]});
	endtask
	// Print counts and verdict, then end the run
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Watchdog against a hung run
	initial begin
		#20000;
		errors++;
		stop_test();
	end
	// Main sequence: reset, table rows, then a mid-run reset
	initial begin
		{rst, wr_en, rd_en, pw_unlocked, addr, wr_data} = {1'b1, 3'h0, 16'h0000};
		errors = 0;
		check_count = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd_chk(8'h0f, 8'h08, 12'h44c);
		rd_chk(8'h10, 8'h08, 12'h44c);
		foreach (rows[i]) begin
			acc(rows[i].a, rows[i].d, rows[i].u, 1'b1);
			rd_chk(rows[i].a, rows[i].rd, rows[i].sp);
		end
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd_chk(8'h0f, 8'h08, 12'h44c);
		rd_chk(8'h10, 8'h08, 12'h44c);
		stop_test();
	end
endmodule
